//--- mifc_pkg.sv
// package of the motion interrupt and buffer configuration block
// assumes one 20 MHz clock and a word-addressed register bus
`default_nettype none
package mifc_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int TICK_HZ = 250;
  localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam int SEC_TICKS = TICK_HZ;
  // ----------------------------------------
  // register indices (byte address is four times these)
  // ----------------------------------------
  localparam logic [5:0] REG_BUF = 6'h12;
  localparam logic [5:0] REG_PIN = 6'h13;
  localparam logic [5:0] REG_SRC = 6'h14;
  localparam logic [5:0] REG_FMT = 6'h16;
  localparam logic [5:0] REG_ATHR = 6'h17;
  localparam logic [5:0] REG_STHR = 6'h18;
  localparam logic [5:0] REG_ADUR = 6'h19;
  localparam logic [5:0] REG_SDUR = 6'h1A;
  localparam logic [5:0] REG_LIM = 6'h1E;
  localparam logic [5:0] REG_STAT = 6'h21;
  localparam logic [7:0] REG_RST = 8'h00;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int PIN_POL = 7;
  localparam int PIN_PULSE = 6;
  localparam int PIN_OD = 5;
  localparam int PIN_RDALL = 4;
  localparam int PIN_RDACT = 3;
  localparam int SRC_GDRDY = 5;
  localparam int SRC_GWM = 4;
  localparam int SRC_AWM = 3;
  localparam int SRC_FF = 2;
  localparam int SRC_ACT = 1;
  localparam int SRC_STILL = 0;
  localparam int FMT_LINK = 2;
  localparam logic [7:0] PIN_MASK = 8'hF8;
  localparam logic [7:0] SRC_MASK = 8'h3F;
  localparam logic [7:0] FMT_MASK = 8'h07;

  typedef enum logic [1:0] {
    MIFC_NOBUF = 2'h0,
    MIFC_FIFO = 2'h1,
    MIFC_STREAM = 2'h2,
    MIFC_TRIGGER = 2'h3
  } mifc_buf_mode_t;

  typedef struct packed {
    logic waitreq;
    logic [7:0] rdata;
    logic [7:0] buf_cfg;
    logic [7:0] pin_cfg;
    logic [7:0] src_en;
    logic [7:0] fmt;
    logic [7:0] act_thr;
    logic [7:0] still_thr;
    logic [7:0] act_dur;
    logic [7:0] still_dur;
    logic [7:0] cnt_lim;
    logic [5:0] pend;
    logic [7:0] act_cnt;
    logic [7:0] still_sec;
    logic still_below;
    logic [19:0] sub_cnt;
    logic [7:0] sec_div;
    logic [8:0] age;
    logic last_act;
    logic half_link;
    logic irq_on;
    logic wm_hit;
    logic pin_o;
    logic pin_oe;
  } mifc_state_t;
endpackage
`default_nettype wire

//--- mifc_top.sv
// motion interrupt, event linking and buffer configuration logic
// assumes sensor inputs come from logic on the same clock
`default_nettype none
module mifc_top #(
  parameter int TICK_CYCLES = mifc_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // sensor core events
  input wire logic accel_sample_valid,
  input wire logic [15:0] accel_magnitude,
  input wire logic [5:0] accel_fill_level,
  input wire logic angular_rate_sensor_data_ready,
  input wire logic angular_rate_sensor_watermark,
  input wire logic free_fall_event,
  // configuration towards the sensor core
  output mifc_pkg::mifc_buf_mode_t buffer_mode,
  output logic [5:0] buffer_level,
  output logic [1:0] accel_range,
  output logic accel_watermark,
  // interrupt pin
  output logic irq_pin_o,
  output logic irq_pin_oe
);
  initial begin
    if (TICK_CYCLES < 2 || TICK_CYCLES >= 2 ** 20) begin
      $error("TICK_CYCLES out of range");
    end
  end

  mifc_pkg::mifc_state_t s_ff;
  mifc_pkg::mifc_state_t nxt_s;

  // ----------------------------------------
  // bus strobes
  // ----------------------------------------
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic stat_rd;
  assign acc = (avs_read || avs_write) && !s_ff.waitreq;
  assign wr_acc = avs_write && !s_ff.waitreq;
  assign rd_acc = avs_read && !s_ff.waitreq;
  assign stat_rd = rd_acc && avs_address == mifc_pkg::REG_STAT;

  // threshold in mg: count shifted by 3, 4 or 5
  function automatic logic [15:0] to_mg(input logic [7:0] t, input logic [1:0] r);
    logic [15:0] v;
    v = {8'h00, t};
    case (r)
      2'h0: to_mg = v << 3;
      2'h1: to_mg = v << 4;
      default: to_mg = v << 5;
    endcase
  endfunction

  logic [15:0] act_mg;
  logic [15:0] still_mg;
  logic [7:0] act_need;
  logic [7:0] still_need;
  assign act_mg = to_mg(s_ff.act_thr, s_ff.fmt[1:0]);
  assign still_mg = to_mg(s_ff.still_thr, s_ff.fmt[1:0]);
  assign act_need = (s_ff.act_dur == 8'h00) ? 8'h01 : s_ff.act_dur;
  assign still_need = (s_ff.still_dur == 8'h00) ? 8'h01 : s_ff.still_dur;

  logic tick;
  logic sec_tick;
  logic det_act;
  logic det_still;
  logic fire_act;
  logic fire_still;
  logic [5:0] ev;
  logic [5:0] clr;
  logic expire;

  always_comb begin
    nxt_s = s_ff;
    tick = 1'b0;
    sec_tick = 1'b0;
    det_act = 1'b0;
    det_still = 1'b0;
    fire_act = 1'b0;
    fire_still = 1'b0;
    clr = 6'h00;
    expire = 1'b0;
    // ----------------------------------------
    // avalon slave: one wait cycle, then accept
    // ----------------------------------------
    if ((avs_read || avs_write) && s_ff.waitreq) begin
      nxt_s.waitreq = 1'b0;
      nxt_s.rdata = 8'h00;
      if (avs_read) begin
        if (avs_address == mifc_pkg::REG_BUF) begin
          nxt_s.rdata = s_ff.buf_cfg;
        end else if (avs_address == mifc_pkg::REG_PIN) begin
          nxt_s.rdata = s_ff.pin_cfg;
        end else if (avs_address == mifc_pkg::REG_SRC) begin
          nxt_s.rdata = s_ff.src_en;
        end else if (avs_address == mifc_pkg::REG_FMT) begin
          nxt_s.rdata = s_ff.fmt;
        end else if (avs_address == mifc_pkg::REG_ATHR) begin
          nxt_s.rdata = s_ff.act_thr;
        end else if (avs_address == mifc_pkg::REG_STHR) begin
          nxt_s.rdata = s_ff.still_thr;
        end else if (avs_address == mifc_pkg::REG_ADUR) begin
          nxt_s.rdata = s_ff.act_dur;
        end else if (avs_address == mifc_pkg::REG_SDUR) begin
          nxt_s.rdata = s_ff.still_dur;
        end else if (avs_address == mifc_pkg::REG_LIM) begin
          nxt_s.rdata = s_ff.cnt_lim;
        end else if (avs_address == mifc_pkg::REG_STAT) begin
          nxt_s.rdata = {2'h0, s_ff.pend};
        end
      end
    end else begin
      nxt_s.waitreq = 1'b1;
    end
    // reserved bits masked off on write
    if (wr_acc) begin
      if (avs_address == mifc_pkg::REG_BUF) begin
        nxt_s.buf_cfg = avs_writedata[7:0];
      end else if (avs_address == mifc_pkg::REG_PIN) begin
        nxt_s.pin_cfg = avs_writedata[7:0] & mifc_pkg::PIN_MASK;
      end else if (avs_address == mifc_pkg::REG_SRC) begin
        nxt_s.src_en = avs_writedata[7:0] & mifc_pkg::SRC_MASK;
      end else if (avs_address == mifc_pkg::REG_FMT) begin
        nxt_s.fmt = avs_writedata[7:0] & mifc_pkg::FMT_MASK;
      end else if (avs_address == mifc_pkg::REG_ATHR) begin
        nxt_s.act_thr = avs_writedata[7:0];
      end else if (avs_address == mifc_pkg::REG_STHR) begin
        nxt_s.still_thr = avs_writedata[7:0];
      end else if (avs_address == mifc_pkg::REG_ADUR) begin
        nxt_s.act_dur = avs_writedata[7:0];
      end else if (avs_address == mifc_pkg::REG_SDUR) begin
        nxt_s.still_dur = avs_writedata[7:0];
      end else if (avs_address == mifc_pkg::REG_LIM) begin
        nxt_s.cnt_lim = avs_writedata[7:0];
      end
    end
    // ----------------------------------------
    // 250 Hz and 1 Hz timebases
    // ----------------------------------------
    if (s_ff.sub_cnt == 20'(TICK_CYCLES - 1)) begin
      nxt_s.sub_cnt = 20'h00000;
      tick = 1'b1;
    end else begin
      nxt_s.sub_cnt = s_ff.sub_cnt + 20'h00001;
    end
    if (tick) begin
      if (s_ff.sec_div == 8'(mifc_pkg::SEC_TICKS - 1)) begin
        nxt_s.sec_div = 8'h00;
        sec_tick = 1'b1;
      end else begin
        nxt_s.sec_div = s_ff.sec_div + 8'h01;
      end
    end
    // ----------------------------------------
    // activity and inactivity detection
    // ----------------------------------------
    if (accel_sample_valid) begin
      if (accel_magnitude > act_mg) begin
        if (s_ff.act_cnt < act_need) begin
          nxt_s.act_cnt = s_ff.act_cnt + 8'h01;
          det_act = (s_ff.act_cnt + 8'h01) == act_need;
        end
      end else begin
        nxt_s.act_cnt = 8'h00;
      end
      // any sample at or above the threshold restarts the second count
      if (accel_magnitude < still_mg) begin
        nxt_s.still_below = 1'b1;
      end else begin
        nxt_s.still_below = 1'b0;
        nxt_s.still_sec = 8'h00;
      end
    end
    if (sec_tick && s_ff.still_below && nxt_s.still_below) begin
      if (s_ff.still_sec < still_need) begin
        nxt_s.still_sec = s_ff.still_sec + 8'h01;
        det_still = (s_ff.still_sec + 8'h01) == still_need;
      end
    end
    // ----------------------------------------
    // activity / inactivity linking
    // ----------------------------------------
    if (!s_ff.fmt[mifc_pkg::FMT_LINK]) begin
      fire_act = det_act;
      fire_still = det_still;
      if (det_act) begin
        nxt_s.last_act = 1'b1;
      end else if (det_still) begin
        nxt_s.last_act = 1'b0;
      end
      nxt_s.half_link = 1'b0;
    end else if (det_act) begin
      if (s_ff.last_act || s_ff.half_link) begin
        fire_act = 1'b1;
        nxt_s.last_act = 1'b1;
        nxt_s.half_link = 1'b0;
      end else begin
        nxt_s.half_link = 1'b1;
      end
    end else if (det_still) begin
      if (!s_ff.last_act || s_ff.half_link) begin
        fire_still = 1'b1;
        nxt_s.last_act = 1'b0;
        nxt_s.half_link = 1'b0;
      end else begin
        nxt_s.half_link = 1'b1;
      end
    end
    // ----------------------------------------
    // buffer watermark
    // ----------------------------------------
    nxt_s.wm_hit = (s_ff.buf_cfg[7:6] == mifc_pkg::MIFC_FIFO)
                   && accel_fill_level >= s_ff.buf_cfg[5:0];
    // ----------------------------------------
    // pending flags: set wins over clear
    // ----------------------------------------
    if (stat_rd || (rd_acc && s_ff.pin_cfg[mifc_pkg::PIN_RDALL])) begin
      clr = 6'h3F;
    end
    if (rd_acc && s_ff.pin_cfg[mifc_pkg::PIN_RDACT]) begin
      clr[mifc_pkg::SRC_ACT] = 1'b1;
    end
    if (s_ff.pend == 6'h00) begin
      nxt_s.age = 9'h000;
    end else if (tick && s_ff.age != 9'h1FF) begin
      nxt_s.age = s_ff.age + 9'h001;
    end
    if (s_ff.pin_cfg[mifc_pkg::PIN_PULSE] && s_ff.age > {1'b0, s_ff.cnt_lim}) begin
      expire = 1'b1;
      clr = 6'h3F;
      nxt_s.age = 9'h000;
    end
    nxt_s.pend = (s_ff.pend & ~clr) | (ev & s_ff.src_en[5:0]);
    // ----------------------------------------
    // interrupt pin
    // ----------------------------------------
    nxt_s.irq_on = nxt_s.pend != 6'h00;
    if (s_ff.pin_cfg[mifc_pkg::PIN_OD]) begin
      nxt_s.pin_o = 1'b0;
      nxt_s.pin_oe = nxt_s.irq_on ^ ~s_ff.pin_cfg[mifc_pkg::PIN_POL];
    end else begin
      nxt_s.pin_o = nxt_s.irq_on ^ s_ff.pin_cfg[mifc_pkg::PIN_POL];
      nxt_s.pin_oe = 1'b1;
    end
    if (reset) begin
      nxt_s = '0;
      nxt_s.waitreq = 1'b1;
      nxt_s.pin_oe = 1'b1;
    end
  end

  // event vector in enable-bit order
  always_comb begin
    ev = 6'h00;
    ev[mifc_pkg::SRC_GDRDY] = angular_rate_sensor_data_ready;
    ev[mifc_pkg::SRC_GWM] = angular_rate_sensor_watermark;
    ev[mifc_pkg::SRC_AWM] = s_ff.wm_hit;
    ev[mifc_pkg::SRC_FF] = free_fall_event;
    ev[mifc_pkg::SRC_ACT] = fire_act;
    ev[mifc_pkg::SRC_STILL] = fire_still;
  end

  always_ff @(posedge clock) begin
    s_ff <= nxt_s;
  end

  assign avs_readdata = {24'h000000, s_ff.rdata};
  assign avs_waitrequest = s_ff.waitreq;
  assign buffer_mode = mifc_pkg::mifc_buf_mode_t'(s_ff.buf_cfg[7:6]);
  assign buffer_level = s_ff.buf_cfg[5:0];
  assign accel_range = s_ff.fmt[1:0];
  assign accel_watermark = s_ff.wm_hit;
  assign irq_pin_o = s_ff.pin_o;
  assign irq_pin_oe = s_ff.pin_oe;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_wait_one: assert property (@(posedge clock) disable iff (reset)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus did not answer after one wait cycle");
  a_pol_pp: assert property (@(posedge clock) disable iff (reset)
    !s_ff.pin_cfg[5] && !$changed(s_ff.pin_cfg) |-> irq_pin_oe
    && irq_pin_o == (s_ff.irq_on ^ s_ff.pin_cfg[7]))
    else $error("push-pull level wrong");
  a_od_drive: assert property (@(posedge clock) disable iff (reset)
    s_ff.pin_cfg[5] && $stable(s_ff.pin_cfg) |-> !irq_pin_o
    && irq_pin_oe == (s_ff.irq_on ^ !s_ff.pin_cfg[7]))
    else $error("open-drain drive wrong");
  a_latch_hold: assert property (@(posedge clock) disable iff (reset)
    s_ff.irq_on && !s_ff.pin_cfg[6] && !avs_read |=> s_ff.irq_on)
    else $error("latched interrupt dropped without a read");
  a_stat_clear: assert property (@(posedge clock) disable iff (reset)
    stat_rd && ev == 6'h00 |=> s_ff.pend == 6'h00)
    else $error("status read did not clear");
  a_src_gate: assert property (@(posedge clock) disable iff (reset)
    $rose(s_ff.pend[1]) |-> $past(s_ff.src_en[1]) && $past(fire_act))
    else $error("activity flag set while disabled");
  a_act_read: assert property (@(posedge clock) disable iff (reset)
    rd_acc && s_ff.pin_cfg[3] && !fire_act |=> !s_ff.pend[1])
    else $error("activity flag survived any-read clear");
  a_link_two: assert property (@(posedge clock) disable iff (reset)
    s_ff.fmt[2] && det_act && !s_ff.last_act && !s_ff.half_link |-> !fire_act)
    else $error("linked activity fired on first detection");
  a_nolink_one: assert property (@(posedge clock) disable iff (reset)
    !s_ff.fmt[2] && det_still |-> fire_still)
    else $error("unlinked inactivity not fired");
  a_auto_end: assert property (@(posedge clock) disable iff (reset)
    expire && ev == 6'h00 |=> !s_ff.irq_on ##1 s_ff.age == 9'h000)
    else $error("non-latched interrupt not ended");
endmodule
`default_nettype wire

//--- mifc_host_model.sv
// host end of the interrupt line: pull-up and input buffer
// assumes the block splits the pin into value and output enable
`default_nettype none
module mifc_host_model (
  // pin from the block
  input wire logic irq_pin_o,
  input wire logic irq_pin_oe,
  // level seen by the host
  output logic irq_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // a released line floats up through the host's pull-up
  assign irq_level = irq_pin_oe ? irq_pin_o : 1'b1;
endmodule
`default_nettype wire

//--- mifc_top_test.sv
// self-checking bench of the motion interrupt configuration block
// assumes mifc_pkg, mifc_top and mifc_host_model are compiled first
`default_nettype none
module mifc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  // short tick so a 1 s stillness window is 5000 cycles
  localparam int TCK = 20;
  logic clock;
  logic reset;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic accel_sample_valid;
  logic [15:0] accel_magnitude;
  logic [5:0] accel_fill_level;
  logic angular_rate_sensor_data_ready;
  logic angular_rate_sensor_watermark;
  logic free_fall_event;
  mifc_pkg::mifc_buf_mode_t buffer_mode;
  logic [5:0] buffer_level;
  logic [1:0] accel_range;
  logic accel_watermark;
  logic irq_pin_o;
  logic irq_pin_oe;
  logic irq_level;
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] exp_q[$];
  logic [7:0] wv;
  logic [5:0] regs[11] = '{6'h12, 6'h13, 6'h14, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1A,
                           6'h1E, 6'h21, 6'h00};
  int srcs[4] = '{5, 4, 3, 2};
  logic [7:0] pcs[3] = '{8'h80, 8'hA0, 8'h20};

  mifc_top #(.TICK_CYCLES(TCK)) dut_u (
    .clock(clock), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .accel_sample_valid(accel_sample_valid), .accel_magnitude(accel_magnitude),
    .accel_fill_level(accel_fill_level), .angular_rate_sensor_data_ready(angular_rate_sensor_data_ready),
    .angular_rate_sensor_watermark(angular_rate_sensor_watermark), .free_fall_event(free_fall_event),
    .buffer_mode(buffer_mode), .buffer_level(buffer_level), .accel_range(accel_range),
    .accel_watermark(accel_watermark), .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe)
  );
  mifc_host_model host_u (.irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe),
                          .irq_level(irq_level));

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("FAIL %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic end_sim;
    if (n_fail == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // one extra edge at the end keeps a strobe from being driven twice in a step
  task automatic bus(input logic [5:0] a, input logic wr, input logic [7:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] want);
    exp_q.push_back({24'h0, want});
    bus(a, 1'b0, 8'h00);
  endtask
  task automatic pin(input logic lvl, input logic oe);
    repeat (3) @(posedge clock);
    check({30'h0, irq_pin_oe, irq_level}, {30'h0, oe, lvl});
  endtask
  task automatic kick(input int b);
    case (b)
      5: angular_rate_sensor_data_ready <= 1'b1;
      4: angular_rate_sensor_watermark <= 1'b1;
      3: accel_fill_level <= 6'h08;
      default: free_fall_event <= 1'b1;
    endcase
    @(posedge clock);
    {angular_rate_sensor_data_ready, angular_rate_sensor_watermark, free_fall_event} <= 3'h0;
    accel_fill_level <= 6'h00;
  endtask
  task automatic samp(input logic [15:0] m, input int n);
    repeat (n) begin
      accel_sample_valid <= 1'b1;
      accel_magnitude <= m;
      @(posedge clock);
      accel_sample_valid <= 1'b0;
      repeat (2) @(posedge clock);
    end
  endtask
  task automatic do_reset;
    reset <= 1'b1;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
  endtask

  // ----------------------------------------
  // clock, timeout and read-data monitor
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles > 30000) begin
      n_fail++;
      end_sim();
    end
    if (avs_read && avs_waitrequest === 1'b0) begin
      if (exp_q.size() > 0) check(avs_readdata, exp_q.pop_front());
      else check(avs_readdata, 32'hFFFFFFFF);
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    {avs_read, avs_write, avs_writedata, avs_address, accel_sample_valid, accel_magnitude,
     accel_fill_level, angular_rate_sensor_data_ready, angular_rate_sensor_watermark, free_fall_event} = '0;
    void'($urandom(43489));
    do_reset();
    check({30'h0, irq_pin_oe, irq_level}, 32'h2);
    foreach (regs[k]) rd(regs[k], 8'h00);
    wr(6'h00, 8'hFF);
    rd(6'h00, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wv = 8'($urandom());
      wr(mifc_pkg::REG_BUF, {i[1:0], wv[5:0]});
      rd(mifc_pkg::REG_BUF, {i[1:0], wv[5:0]});
      check({30'h0, buffer_mode}, {30'h0, i[1:0]});
      check({26'h0, buffer_level}, {26'h0, wv[5:0]});
      wr(mifc_pkg::REG_PIN, wv);
      rd(mifc_pkg::REG_PIN, wv & mifc_pkg::PIN_MASK);
      wr(mifc_pkg::REG_SRC, wv);
      rd(mifc_pkg::REG_SRC, wv & mifc_pkg::SRC_MASK);
      wr(mifc_pkg::REG_FMT, {wv[7:2], i[1:0]});
      rd(mifc_pkg::REG_FMT, {wv[7:2], i[1:0]} & mifc_pkg::FMT_MASK);
      check({30'h0, accel_range}, {30'h0, i[1:0]});
      wr(mifc_pkg::REG_STHR, ~wv);
      rd(mifc_pkg::REG_STHR, ~wv);
    end
    // random enables above may have left flags pending
    do_reset();
    // watermark level compared against the fill only in FIFO mode
    wr(mifc_pkg::REG_PIN, 8'h00);
    wr(mifc_pkg::REG_FMT, 8'h00);
    wr(mifc_pkg::REG_BUF, 8'h48);
    accel_fill_level <= 6'h07;
    repeat (3) @(posedge clock);
    check({31'h0, accel_watermark}, 32'h0);
    accel_fill_level <= 6'h08;
    repeat (3) @(posedge clock);
    check({31'h0, accel_watermark}, 32'h1);
    wr(mifc_pkg::REG_BUF, 8'h88);
    // flag follows the new mode one edge after the write lands
    @(posedge clock);
    check({31'h0, accel_watermark}, 32'h0);
    accel_fill_level <= 6'h00;
    wr(mifc_pkg::REG_BUF, 8'h48);
    foreach (srcs[k]) begin
      wr(mifc_pkg::REG_SRC, 8'h00);
      kick(srcs[k]);
      pin(1'b0, 1'b1);
      rd(mifc_pkg::REG_STAT, 8'h00);
      wr(mifc_pkg::REG_SRC, 8'(1 << srcs[k]));
      kick(srcs[k]);
      pin(1'b1, 1'b1);
      rd(mifc_pkg::REG_LIM, 8'h00);
      pin(1'b1, 1'b1);
      rd(mifc_pkg::REG_STAT, 8'(1 << srcs[k]));
      pin(1'b0, 1'b1);
    end
    foreach (pcs[k]) begin
      wr(mifc_pkg::REG_PIN, pcs[k]);
      wr(mifc_pkg::REG_SRC, 8'h04);
      pin(pcs[k][7], !(pcs[k][5] && pcs[k][7]));
      kick(2);
      pin(!pcs[k][7], !(pcs[k][5] && !pcs[k][7]));
      rd(mifc_pkg::REG_STAT, 8'h04);
    end
    wr(mifc_pkg::REG_PIN, 8'h10);
    kick(2);
    pin(1'b1, 1'b1);
    rd(mifc_pkg::REG_LIM, 8'h00);
    pin(1'b0, 1'b1);
    // activity: 2 counts of 8 mg, 3 samples strictly above 16 mg
    wr(mifc_pkg::REG_PIN, 8'h00);
    wr(mifc_pkg::REG_SRC, 8'h06);
    wr(mifc_pkg::REG_ATHR, 8'h02);
    wr(6'h19, 8'h03);
    samp(16'd17, 2);
    samp(16'd16, 1);
    samp(16'd17, 2);
    rd(mifc_pkg::REG_STAT, 8'h00);
    samp(16'd17, 1);
    rd(mifc_pkg::REG_STAT, 8'h02);
    wr(mifc_pkg::REG_FMT, 8'h01);
    samp(16'd20, 3);
    rd(mifc_pkg::REG_STAT, 8'h00);
    wr(mifc_pkg::REG_PIN, 8'h08);
    samp(16'd33, 3);
    kick(2);
    rd(mifc_pkg::REG_LIM, 8'h00);
    rd(mifc_pkg::REG_STAT, 8'h04);
    // non-latched pulse ends once age passes a limit of 2 ticks
    wr(mifc_pkg::REG_PIN, 8'h40);
    wr(mifc_pkg::REG_LIM, 8'h02);
    kick(2);
    repeat (20) @(posedge clock);
    pin(1'b1, 1'b1);
    repeat (80) @(posedge clock);
    pin(1'b0, 1'b1);
    rd(mifc_pkg::REG_STAT, 8'h00);
    // link on from a fresh reset: first activity is held back
    do_reset();
    wr(mifc_pkg::REG_FMT, 8'h04);
    wr(mifc_pkg::REG_ATHR, 8'h02);
    wr(6'h19, 8'h01);
    wr(mifc_pkg::REG_SRC, 8'h02);
    samp(16'd17, 1);
    rd(mifc_pkg::REG_STAT, 8'h00);
    // a quiet sample rearms the consecutive count between detections
    samp(16'd16, 1);
    samp(16'd17, 1);
    rd(mifc_pkg::REG_STAT, 8'h02);
    samp(16'd16, 1);
    samp(16'd17, 1);
    rd(mifc_pkg::REG_STAT, 8'h02);
    // stillness: 31 mg sits below 1 count in 16g range for 1 s
    wr(mifc_pkg::REG_FMT, 8'h02);
    wr(mifc_pkg::REG_STHR, 8'h01);
    wr(6'h1A, 8'h01);
    wr(mifc_pkg::REG_SRC, 8'h01);
    for (int i = 0; i < 110; i++) begin
      samp(16'd31, 1);
      repeat (47) @(posedge clock);
      if (i == 89) rd(mifc_pkg::REG_STAT, 8'h00);
    end
    rd(mifc_pkg::REG_STAT, 8'h01);
    end_sim();
  end
endmodule
`default_nettype wire
